/* src/gain_match_consts.vh */
`ifndef GAIN_MATCH_CONSTS_VH
`define GAIN_MATCH_CONSTS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_GEAR_CTRL      8'h36
`define IDX_GAIN_CTRL      8'h3c
`define IDX_UPDATE_RATE    8'h3d
`define IDX_GAIN_STATUS    8'h3e
`define IDX_GAIN_VALUE0    8'h3f
`define IDX_GAIN_VALUE1    8'h40
`define IDX_GAIN_VALUE2    8'h41

// ****************************************************************
// Field positions
// ****************************************************************
`define GEAR_LOW_BIT       0
`define GAIN_HOLD_BIT      3
`define GAIN_EN_MSB        2
`define GAIN_EN_LSB        0
`define GAIN_TEST_MSB      7
`define GAIN_TEST_LSB      4

// ****************************************************************
// Field codes and reset values
// ****************************************************************
`define GAIN_EN_OFF        3'h0
`define GAIN_EN_ON         3'h6
`define GEAR_CTRL_RST      8'h00
`define GAIN_CTRL_RST      8'h00
`define UPDATE_RATE_RST    8'h40

// ****************************************************************
// Gain loop
// ****************************************************************
`define GAIN_WIDTH         10
`define GAIN_MID           10'h200
`define GAIN_MAX           10'h3ff
`define GAIN_MIN           10'h000
`define SETTLE_UPDATES     4'ha

`endif

/* src/gain_match_loop.v */
`timescale 1ns/1ps
`include "gain_match_consts.vh"

module gain_match_loop (
  input  wire        pclk,       // System clock
  input  wire        presetn,    // Async reset, active low
  input  wire        loop_on,    // Gain matching enabled
  input  wire        step,       // One update, one-cycle pulse
  input  wire [2:0]  too_high,   // Channel gain above reference
  output reg  [29:0] gain_flat,  // Three 10-bit gains, ch0 low
  output reg         settled     // Approximation finished
);

  reg [3:0] pos_r; // Bit under trial; 10 means tracking
  integer   c;

  // ****************************************************************
  // Next gain of one channel
  // ****************************************************************
  function [9:0] next_gain;
    input [9:0] g;
    input       hi;
    input [3:0] pos;
    reg   [9:0] t;
    begin
      t = g;
      if (pos < `SETTLE_UPDATES) begin
        // Decide trial bit, then try the next lower one
        if (hi) t[pos] = 1'b0;
        if (pos != 4'h0) t[pos - 4'h1] = 1'b1;
      end else if (hi) begin
        if (g != `GAIN_MIN) t = g - 10'h001;
      end else begin
        if (g != `GAIN_MAX) t = g + 10'h001;
      end
      next_gain = t;
    end
  endfunction

  // ****************************************************************
  // Successive approximation, then slow tracking
  // ****************************************************************
  // One bit per update bounds settling to ten updates; the
  // later one-step tracking follows drift without big jumps.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_flat <= {3{`GAIN_MID}};
      pos_r     <= 4'h9;
      settled   <= 1'b0;
    end else if (!loop_on) begin
      gain_flat <= {3{`GAIN_MID}};
      pos_r     <= 4'h9;
      settled   <= 1'b0;
    end else if (step) begin
      for (c = 0; c < 3; c = c + 1) begin
        gain_flat[c*10 +: 10] <= next_gain(gain_flat[c*10 +: 10],
                                           too_high[c], pos_r);
      end
      if (pos_r == 4'h0) begin
        pos_r   <= `SETTLE_UPDATES;
        settled <= 1'b1;
      end else if (pos_r < `SETTLE_UPDATES) begin
        pos_r <= pos_r - 4'h1;
      end
    end
  end

endmodule // gain_match_loop

/* src/gain_match_control.v */
`timescale 1ns/1ps
`include "gain_match_consts.vh"

module gain_match_control (
  input  wire        pclk,       // Clock, 25 MHz
  input  wire        presetn,    // Async reset, active low
  input  wire        psel,       // APB select
  input  wire        penable,    // APB access phase
  input  wire        pwrite,     // APB write
  input  wire [11:0] paddr,      // APB byte address
  input  wire [31:0] pwdata,     // APB write data
  output reg  [31:0] prdata,     // APB read data
  output reg         pready,     // APB ready
  output reg         pslverr,    // APB error, unmapped address
  input  wire        hsync_pls,  // Horizontal sync, one-cycle pulse
  input  wire [2:0]  too_high,   // Per channel: gain above reference
  output reg         gear_low,   // Oscillator low gear select
  output reg  [9:0]  gain0,      // Channel 0 gain
  output reg  [9:0]  gain1,      // Channel 1 gain
  output reg  [9:0]  gain2,      // Channel 2 gain
  output reg         gain_settled // Loop has settled
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [7:0]  gear_ctrl_r;   // Oscillator gear control
  reg  [7:0]  gain_ctrl_r;   // Hold, enable and test bits
  reg  [7:0]  rate_r;        // Hsyncs per update
  reg  [7:0]  hcnt_r;        // Hsyncs seen in this interval
  reg  [3:0]  upd_cnt_r;     // Updates since enable, saturating
  reg         step_r;        // Update strobe to the loop
  wire [29:0] gain_flat;     // Loop gains
  wire        settled;       // Loop settled
  wire        loop_on;       // Enable code is the on code
  wire        updating;      // Loop is allowed to move
  wire        setup;         // APB setup cycle
  wire        wr_en;         // APB write commits
  wire [7:0]  idx;           // Register index
  wire        mapped;        // Index hits a register

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Reserved enable codes leave the loop off: safest undefined case
  assign loop_on = (gain_ctrl_r[`GAIN_EN_MSB:`GAIN_EN_LSB]
                    == `GAIN_EN_ON);
  // Hold bit set lets updates run, cleared freezes the gains
  assign updating = loop_on & gain_ctrl_r[`GAIN_HOLD_BIT];
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;
  assign idx = paddr[9:2];

  // Index decode used by the read, write and error paths
  function is_mapped;
    input [7:0] i;
    begin
      is_mapped = (i == `IDX_GEAR_CTRL) | (i == `IDX_GAIN_CTRL) |
                  (i == `IDX_UPDATE_RATE) | (i == `IDX_GAIN_STATUS) |
                  (i == `IDX_GAIN_VALUE0) | (i == `IDX_GAIN_VALUE1) |
                  (i == `IDX_GAIN_VALUE2);
    end
  endfunction

  assign mapped = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0) &
                  is_mapped(idx);

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Test bits are stored as written but steer nothing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gear_ctrl_r <= `GEAR_CTRL_RST;
      gain_ctrl_r <= `GAIN_CTRL_RST;
      rate_r      <= `UPDATE_RATE_RST;
    end else if (wr_en & mapped) begin
      case (idx)
        `IDX_GEAR_CTRL: begin
          gear_ctrl_r <= {7'h00, pwdata[`GEAR_LOW_BIT]};
        end
        `IDX_GAIN_CTRL: begin
          gain_ctrl_r <= pwdata[7:0];
        end
        `IDX_UPDATE_RATE: begin
          rate_r <= pwdata[7:0];
        end
        default: begin
          gear_ctrl_r <= gear_ctrl_r;
        end
      endcase
    end
  end

  // ****************************************************************
  // APB answer, no wait states
  // ****************************************************************
  // Read data is captured in setup so it stands through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= ~mapped;
      prdata  <= 32'h00000000;
      if (mapped & ~pwrite) begin
        case (idx)
          `IDX_GEAR_CTRL:   prdata <= {24'h000000, gear_ctrl_r};
          `IDX_GAIN_CTRL:   prdata <= {24'h000000, gain_ctrl_r};
          `IDX_UPDATE_RATE: prdata <= {24'h000000, rate_r};
          `IDX_GAIN_STATUS: prdata <= {26'h0, upd_cnt_r,
                                       loop_on, settled};
          `IDX_GAIN_VALUE0: prdata <= {22'h0, gain_flat[9:0]};
          `IDX_GAIN_VALUE1: prdata <= {22'h0, gain_flat[19:10]};
          `IDX_GAIN_VALUE2: prdata <= {22'h0, gain_flat[29:20]};
          default:          prdata <= 32'h00000000;
        endcase
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ****************************************************************
  // Update pacing from horizontal syncs
  // ****************************************************************
  // A rate of zero acts as one, so the loop can never stall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_r    <= 8'h00;
      step_r    <= 1'b0;
      upd_cnt_r <= 4'h0;
    end else if (!updating) begin
      hcnt_r <= 8'h00;
      step_r <= 1'b0;
      if (!loop_on) upd_cnt_r <= 4'h0;
    end else if (hsync_pls) begin
      if ((hcnt_r + 8'h01 >= rate_r) | (rate_r == 8'h00)) begin
        hcnt_r <= 8'h00;
        step_r <= 1'b1;
        if (upd_cnt_r != 4'hf) upd_cnt_r <= upd_cnt_r + 4'h1;
      end else begin
        hcnt_r <= hcnt_r + 8'h01;
        step_r <= 1'b0;
      end
    end else begin
      step_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Gain loop
  // ****************************************************************
  gain_match_loop u_loop (
    .pclk      (pclk),
    .presetn   (presetn),
    .loop_on   (loop_on),
    .step      (step_r),
    .too_high  (too_high),
    .gain_flat (gain_flat),
    .settled   (settled)
  );

  // ****************************************************************
  // Output flops
  // ****************************************************************
  // Registered copies keep outputs glitch free at the top
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gear_low     <= 1'b0;
      gain0        <= `GAIN_MID;
      gain1        <= `GAIN_MID;
      gain2        <= `GAIN_MID;
      gain_settled <= 1'b0;
    end else begin
      gear_low     <= gear_ctrl_r[`GEAR_LOW_BIT];
      gain0        <= gain_flat[9:0];
      gain1        <= gain_flat[19:10];
      gain2        <= gain_flat[29:20];
      gain_settled <= settled;
    end
  end

endmodule // gain_match_control

/* tb/gain_match_checker.sv */
`timescale 1ns/1ps
`include "gain_match_consts.vh"
// ************
// Checks at the ports of the gain matching control
// ************
module gain_match_checker (
  input wire        pclk,        // Clock
  input wire        presetn,     // Reset
  input wire        psel,        // Select
  input wire        penable,     // Access
  input wire        pwrite,      // Write
  input wire [11:0] paddr,       // Address
  input wire [31:0] pwdata,      // Write data
  input wire [31:0] prdata,      // Read data
  input wire        pready,      // Ready
  input wire        pslverr,     // Error
  input wire        hsync_pls,   // Sync pulse
  input wire [2:0]  too_high,    // Compare
  input wire        gear_low,    // Gear
  input wire [9:0]  gain0,       // Gain 0
  input wire [9:0]  gain1,       // Gain 1
  input wire [9:0]  gain2,       // Gain 2
  input wire        gain_settled // Settled
);
  reg  [7:0]  ctl_r;
  reg  [7:0]  rate_r;
  reg  [2:0]  quiet_r;
  reg  [11:0] hs_r;
  wire        wr   = psel & penable & pready & pwrite & ~pslverr;
  wire        gwr  = wr && paddr == {2'b00, `IDX_GEAR_CTRL, 2'b00};
  wire [11:0] need = 12'd10 * ((rate_r == 8'h00) ? 12'd1 : {4'h0, rate_r});
  // Shadow of writes; gains lag a write by a few cycles, so wait 7
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r   <= 8'h00;
      rate_r  <= 8'h40;
      quiet_r <= 3'h0;
      hs_r    <= 12'h000;
    end else begin
      if (wr && paddr == {2'b00, `IDX_GAIN_CTRL, 2'b00})
        ctl_r <= pwdata[7:0];
      if (wr && paddr == {2'b00, `IDX_UPDATE_RATE, 2'b00})
        rate_r <= pwdata[7:0];
      quiet_r <= wr ? 3'h0 : quiet_r + {2'b00, quiet_r != 3'h7};
      if (wr)
        hs_r <= 12'h000;
      else if (hsync_pls && ctl_r[3:0] == 4'he && hs_r != 12'hfff)
        hs_r <= hs_r + 12'h001;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answer
  chk_ready_one: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_timing: assert property (psel && !penable |=> pready)
    else $error("pready late");
  chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without zero data");
  // Gear bit and gain loop behaviour
  chk_gear_follow: assert property (gwr |-> ##2
    gear_low == $past(pwdata[0], 2)) else $error("gear bit not applied");
  chk_hold_freeze: assert property (quiet_r == 3'h7 && !ctl_r[3]
    |-> $stable({gain0, gain1, gain2})) else $error("gains moved");
  chk_off_mid: assert property (quiet_r == 3'h7 && ctl_r[2:0] != 3'h6
    |-> gain0 == 10'h200 && gain1 == 10'h200 && gain2 == 10'h200
    && !gain_settled) else $error("gains active while off");
  chk_settle_bound: assert property (hs_r >= need
    |-> ##[1:3] gain_settled) else $error("loop not settled");
  cover property (pslverr);
  cover property ($rose(gain_settled));
  cover property (gwr && pwdata[0]);
endmodule // gain_match_checker

bind gain_match_control gain_match_checker gain_match_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .hsync_pls(hsync_pls),
  .too_high(too_high), .gear_low(gear_low), .gain0(gain0),
  .gain1(gain1), .gain2(gain2), .gain_settled(gain_settled));

/* tb/tb_top.sv */
`timescale 1ns/1ps
`include "gain_match_consts.vh"
// ************
// Bench
// ************
module tb_top;
  localparam [31:0] MID = {2'b00, {3{10'h200}}};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        hsync_pls = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, snap, seed = 32'hdbc95a6f;
  logic [2:0]  too_high = 0, th;
  wire  [31:0] prdata;
  wire         pready, pslverr, gear_low, gain_settled;
  wire  [9:0]  gain0, gain1, gain2;
  wire  [31:0] gv = {2'b00, gain2, gain1, gain0};
  int          n_fail = 0, checks_done = 0;
  always #20 pclk = ~pclk;
  gain_match_control gain_match_control_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hsync_pls(hsync_pls), .too_high(too_high),
    .gear_low(gear_low), .gain0(gain0), .gain1(gain1), .gain2(gain2),
    .gain_settled(gain_settled));
  task stop_test;
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One transfer; waits on pready, never on a fixed count
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00}; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // Sync pulses, with random compare results if asked
  task hs(input int n, input logic rnd);
    repeat (n) begin
      repeat (6) @(posedge pclk);
      snap = $random(seed);
      hsync_pls <= 1;
      if (rnd) too_high <= snap[2:0];
      @(posedge pclk);
      hsync_pls <= 0;
    end
  endtask
  // A constant compare drives each channel to one end of the range
  function automatic logic [31:0] gains_of(input logic [2:0] t);
    gains_of = {2'b00, t[2] ? 10'h000 : 10'h3ff,
                t[1] ? 10'h000 : 10'h3ff, t[0] ? 10'h000 : 10'h3ff};
  endfunction
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk({gear_low, gain_settled, gv[29:0]}, MID);
    apb(0, `IDX_GAIN_CTRL, 0); chk(rd, 32'h0);
    apb(0, `IDX_UPDATE_RATE, 0); chk(rd, 32'h40);
    for (int v = 1; v >= 0; v--) begin
      apb(1, `IDX_GEAR_CTRL, v); repeat (2) @(posedge pclk);
      chk({31'h0, gear_low}, v);
      apb(0, `IDX_GEAR_CTRL, 0); chk(rd, v);
    end
    apb(0, 8'h10, 0); chk({rd[30:0], err}, 32'h1);
    apb(1, `IDX_UPDATE_RATE, 2);
    apb(1, `IDX_GAIN_CTRL, 32'h06);
    hs(6, 1); chk(gv, MID);
    snap = $random(seed); th = snap[2:0]; too_high <= th;
    apb(1, `IDX_GAIN_CTRL, 32'h0e);
    hs(20, 0); repeat (4) @(posedge pclk);
    chk({31'h0, gain_settled}, 32'h1);
    chk(gv, gains_of(th));
    // Status: ten updates counted, enabled, settled
    apb(0, `IDX_GAIN_STATUS, 0);
    chk(rd, 32'h0000002b);
    snap = gains_of(th);
    apb(0, `IDX_GAIN_VALUE0, 0);
    chk(rd, {22'h0, snap[9:0]});
    apb(1, `IDX_GAIN_CTRL, 32'h06);
    hs(10, 1); chk(gv, gains_of(th));
    for (int c = 0; c < 8; c++) if (c != 6) begin
      apb(1, `IDX_GAIN_CTRL, 32'h0e); hs(4, 1);
      apb(1, `IDX_GAIN_CTRL, c | 8); hs(2, 1);
      chk({gain_settled, gv[30:0]}, MID);
    end
    stop_test;
  end
  // About thirty times the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    stop_test;
  end
endmodule // tb_top
